// File: dcsp_port.sv
// Functional notes
// - chained operation and active output only while chain enable is high
// - output high impedance while frame sync high or chain enable low
// - frame sync falling with chaining ties shift register end to output
// - output repeats input delayed sixteen serial clocks during chained frame
// - after 16n falling edges, the first falling serial clock after frame sync rises updates all devices together
// - input sampled on each falling serial clock while frame sync low
// - first falling serial clock after frame sync rises loads the last sixteen bits received
// - word is four command bits then twelve data bits, msb first
`timescale 1ns/1ns
module dcsp_port
  import dcsp_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 sclk,
  input  wire logic                 sync_n,
  input  wire logic                 serial_in,
  input  wire logic                 chain_enable_in,
  output logic                      serial_out,
  output logic                      serial_out_oe,
  output logic [CMD_BITS-1:0]       word_cmd,
  output logic [DATA_BITS-1:0]      word_data,
  output logic                      word_valid,
  input  wire logic                 word_ready
);
  // link domain, clocked on falling sclk
  logic [WORD_BITS-1:0] shift;
  logic [WORD_BITS-1:0] next_shift;
  logic [WORD_BITS-1:0] held;
  logic [WORD_BITS-1:0] next_held;
  logic                 load_tgl;
  logic                 next_load_tgl;
  logic                 sync_q;
  logic                 out_bit;
  logic                 next_out_bit;
  dcsp_state_type       state;
  dcsp_state_type       next_state;

  always_comb
  begin
    next_shift    = shift;
    next_held     = held;
    next_load_tgl = load_tgl;
    next_out_bit  = out_bit;
    next_state    = state;
    case (state)
      DCSP_IDLE:
      begin
        if (!sync_n)
        begin
          next_shift   = {shift[WORD_BITS-2:0], serial_in};
          // track the register's end itself, so the delay is sixteen, not seventeen
          next_out_bit = shift[WORD_BITS-2];
          next_state   = DCSP_FRAME;
        end
      end
      DCSP_FRAME:
      begin
        if (!sync_n)
        begin
          next_shift   = {shift[WORD_BITS-2:0], serial_in};
          next_out_bit = shift[WORD_BITS-2];
        end
        else
        begin
          // edge after rising sync: capture the frame, then rearm
          next_held     = shift;
          next_load_tgl = ~load_tgl;
          next_state    = DCSP_IDLE;
        end
      end
      default:
        next_state = DCSP_IDLE;
    endcase
  end

  always_ff @(negedge sclk or posedge rst)
  begin
    if (rst)
    begin
      shift    <= SHIFT_RESET;
      held     <= SHIFT_RESET;
      load_tgl <= TOGGLE_RESET;
      out_bit  <= TOGGLE_RESET;
      state    <= DCSP_IDLE;
    end
    else
    begin
      shift    <= next_shift;
      held     <= next_held;
      load_tgl <= next_load_tgl;
      out_bit  <= next_out_bit;
      state    <= next_state;
    end
  end

  // sync level seen by ref_clk logic for drive enable; pin is sampled directly
  // since the enable must follow frame sync without waiting for an sclk edge
  always_comb
  begin
    sync_q = sync_n;
  end

  // ref_clk domain
  logic [1:0]           tgl_sync;
  logic                 tgl_seen;
  logic [1:0]           en_sync;
  logic [1:0]           fs_sync;
  logic [1:0]           so_sync;
  logic                 fifo_valid_in;
  logic                 fifo_ready_in;
  logic [WORD_BITS-1:0] fifo_out;
  logic                 fifo_out_valid;
  logic                 next_tgl_seen;
  logic                 next_serial_out;
  logic                 next_serial_out_oe;
  logic [CMD_BITS-1:0]  next_word_cmd;
  logic [DATA_BITS-1:0] next_word_data;
  logic                 next_word_valid;
  logic                 take;

  always_comb
  begin
    // held is stable for many sclk edges after a toggle, so it crosses as a bus
    fifo_valid_in      = (tgl_sync[1] != tgl_seen);
    next_tgl_seen      = fifo_valid_in && fifo_ready_in ? tgl_sync[1] : tgl_seen;
    take               = !word_valid || word_ready;
    next_word_valid    = take ? fifo_out_valid : word_valid;
    next_word_cmd      = take ? fifo_out[WORD_BITS-1 -: CMD_BITS] : word_cmd;
    next_word_data     = take ? fifo_out[DATA_BITS-1:0] : word_data;
    next_serial_out    = so_sync[1];
    next_serial_out_oe = dcsp_out_active(fs_sync[1], en_sync[1]);
  end

  dcsp_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .clk       (ref_clk),
    .rst       (rst),
    .in_data   (held),
    .in_valid  (fifo_valid_in),
    .in_ready  (fifo_ready_in),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (take)
  );

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tgl_sync      <= SYNC_RESET;
      tgl_seen      <= TOGGLE_RESET;
      en_sync       <= SYNC_RESET;
      fs_sync       <= ~SYNC_RESET;
      so_sync       <= SYNC_RESET;
      serial_out    <= TOGGLE_RESET;
      serial_out_oe <= TOGGLE_RESET;
      word_cmd      <= ZERO_WORD[CMD_BITS-1:0];
      word_data     <= ZERO_WORD[DATA_BITS-1:0];
      word_valid    <= TOGGLE_RESET;
    end
    else
    begin
      tgl_sync      <= {tgl_sync[0], load_tgl};
      tgl_seen      <= next_tgl_seen;
      en_sync       <= {en_sync[0], chain_enable_in};
      fs_sync       <= {fs_sync[0], sync_q};
      so_sync       <= {so_sync[0], out_bit};
      serial_out    <= next_serial_out;
      serial_out_oe <= next_serial_out_oe;
      word_cmd      <= next_word_cmd;
      word_data     <= next_word_data;
      word_valid    <= next_word_valid;
    end
  end
endmodule : dcsp_port

// File: dcsp_pkg.sv
package dcsp_pkg;
  localparam int WORD_BITS  = 16;
  localparam int CMD_BITS   = 4;
  localparam int DATA_BITS  = 12;
  localparam int FIFO_DEPTH = 32;
  localparam logic [WORD_BITS-1:0] SHIFT_RESET = 16'h0000;
  localparam logic [WORD_BITS-1:0] ZERO_WORD   = 16'h0000;
  localparam logic [1:0] SYNC_RESET = 2'h0;
  localparam logic       TOGGLE_RESET = 1'h0;

  typedef enum logic [1:0]
  {
    DCSP_IDLE  = 2'b00,
    DCSP_FRAME = 2'b01,
    DCSP_ARMED = 2'b10
  } dcsp_state_type;

  function automatic logic dcsp_out_active(input logic sync_n, input logic en);
    dcsp_out_active = en && !sync_n;
  endfunction : dcsp_out_active
endpackage : dcsp_pkg

// File: dcsp_fifo.sv
`timescale 1ns/1ns
module dcsp_fifo
  import dcsp_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             push;
  logic             pop;

  always_comb
  begin
    in_ready    = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    out_valid   = wr_ptr != rd_ptr;
    out_data    = mem[rd_ptr[AW-1:0]];
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + (AW+1)'(1) : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + (AW+1)'(1) : rd_ptr;
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end
endmodule : dcsp_fifo

// File: dcsp_sva.sv
`timescale 1ns/1ns
module dcsp_sva
  import dcsp_pkg::*;
(
  input wire logic                 ref_clk,
  input wire logic                 rst,
  input wire logic                 sclk,
  input wire logic                 sync_n,
  input wire logic                 chain_enable_in,
  input wire logic                 serial_out,
  input wire logic                 serial_out_oe,
  input wire logic [CMD_BITS-1:0]  word_cmd,
  input wire logic [DATA_BITS-1:0] word_data,
  input wire logic                 word_valid,
  input wire logic                 word_ready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_oe_chain_off: assert property ((!chain_enable_in)[*4] |-> !serial_out_oe)
    else $error("oe on with chain off");
  a_oe_sync_high: assert property (sync_n[*4] |-> !serial_out_oe)
    else $error("oe on with sync high");
  a_oe_drop: assert property ($rose(sync_n) |-> ##[1:4] !serial_out_oe)
    else $error("oe late to drop");
  a_oe_in_frame: assert property ((chain_enable_in && !sync_n)[*4] |-> serial_out_oe)
    else $error("oe off in chained frame");
  a_out_still: assert property (($stable(sclk) && $stable(sync_n)
    && $stable(chain_enable_in))[*6] |-> $stable(serial_out))
    else $error("output moved without clock");
  a_word_hold: assert property (word_valid && !word_ready |=> word_valid
    && $stable(word_cmd) && $stable(word_data))
    else $error("word dropped before accept");
  a_no_early_load: assert property ($fell(sync_n) && !word_valid |-> !word_valid[*4])
    else $error("word at frame start");
  a_load_bound: assert property ($rose(sync_n) && chain_enable_in && !word_valid
    |-> ##[1:40] word_valid)
    else $error("no word after frame");
  c_accept: cover property (word_valid && word_ready);
  c_oe_on: cover property ($rose(serial_out_oe));
  c_frame_off: cover property ($fell(sync_n) && !chain_enable_in);
endmodule : dcsp_sva
bind dcsp_port dcsp_sva chk_u (.*);

// File: dcsp_host_model.sv
`timescale 1ns/1ns
module dcsp_host_model
(
  output logic      sclk = 1'b1,
  output logic      sync_n = 1'b1,
  output logic      serial_in = 1'b0,
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  // slow edges so the re-timed output can keep up
  localparam int HALF = 135;
  // two-deep chain: 32 falls on one shared clock and frame
  task automatic frame(input logic [31:0] v, input logic en);
    #7 sync_n = 1'b0;
    for (int e = 0; e < 32; e++)
    begin
      serial_in = v[31-e];
      #HALF;
      if (e > 0) tb_top.check(serial_out_oe, en, "oe");
      if (en && e > 15) tb_top.check(serial_out, v[47-e], "sdo");
      sclk = 1'b0;
      #HALF sclk = 1'b1;
    end
    serial_in = ~serial_in;
    #HALF sync_n = 1'b1;
    #HALF sclk = 1'b0;
    #HALF sclk = 1'b1;
    #300 tb_top.check(serial_out_oe, 1'b0, "oe idle");
    #1000;
  endtask : frame
endmodule : dcsp_host_model

// File: tb_top.sv
`timescale 1ns/1ns
module tb_top
  import dcsp_pkg::*;
;
  logic                 ref_clk;
  logic                 rst = 1'b1;
  logic                 chain_enable_in = 1'b1;
  logic                 word_ready = 1'b0;
  wire                  sclk, sync_n, serial_in, serial_out, serial_out_oe, word_valid;
  wire [CMD_BITS-1:0]   word_cmd;
  wire [DATA_BITS-1:0]  word_data;
  int                   err_count = 0;
  int                   comparisons = 0;
  dcsp_port dut_u (.*);
  dcsp_host_model pm_u (.*);
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [15:0] wd(input int i);
    wd = 16'hA5C3 ^ 16'(i * 16'h0111);
  endfunction : wd
  task automatic fill_drain;
    int n;
    for (int i = 0; i < FIFO_DEPTH; i++)
      pm_u.frame({~wd(i), wd(i)}, 1'b1);
    for (int i = 0; i < FIFO_DEPTH; i++)
    begin
      n = 0;
      @(negedge ref_clk);
      while (word_valid !== 1'b1 && n < 60)
      begin
        @(negedge ref_clk);
        n++;
      end
      check({word_cmd, word_data}, wd(i), "word");
      @(posedge ref_clk);
      word_ready <= 1'b1;
      @(posedge ref_clk);
      word_ready <= 1'b0;
    end
    repeat (2) @(negedge ref_clk);
    check(word_valid, 1'b0, "empty");
    $display("fill_drain done");
  endtask : fill_drain
  task automatic chain_off;
    @(posedge ref_clk);
    chain_enable_in <= 1'b0;
    pm_u.frame(32'h0F0F3C3C, 1'b0);
    $display("chain_off done");
  endtask : chain_off
  task automatic close_out;
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    fill_drain();
    chain_off();
    close_out();
  end
  initial
  begin
    #2000000;
    err_count++;
    close_out();
  end
endmodule : tb_top
